// File: core/tcc_pkg.sv
// Constants, field layout and states of the transmit command word checker
package tcc_pkg;
  // ==========================================
  // Word and field layout
  localparam int TCC_WORD_W = 32;
  localparam int TCC_A_IOC_BIT = 31;
  localparam int TCC_A_ALIGN_LSB = 24;
  localparam int TCC_A_OFF_LSB = 16;
  localparam int TCC_OFF_W = 5;
  localparam int TCC_A_FS_BIT = 13;
  localparam int TCC_A_LS_BIT = 12;
  localparam int TCC_SIZE_W = 11;
  localparam int TCC_B_TAG_LSB = 16;
  localparam int TCC_TAG_W = 16;
  localparam int TCC_B_CK_BIT = 14;
  localparam int TCC_B_NOCRC_BIT = 13;
  localparam int TCC_B_NOPAD_BIT = 12;
  // ==========================================
  // Derived widths
  localparam int TCC_BYTE_W = 12;
  localparam int TCC_WIDX_W = 10;
  localparam int TCC_SUM_W = 16;
  localparam int TCC_LANES = 4;
  localparam int TCC_MIN_FRAME_BYTES = 64;
  // ==========================================
  // Reset values
  localparam logic [TCC_WORD_W-1:0] TCC_CMD_RST = 32'h0000_0000;
  localparam logic [TCC_SUM_W-1:0] TCC_SUM_RST = 16'h0000;
  // ==========================================
  // End alignment codes and their rounding masks
  typedef enum logic [1:0] {
    TCC_ALIGN_4 = 2'b00,
    TCC_ALIGN_16 = 2'b01,
    TCC_ALIGN_32 = 2'b10,
    TCC_ALIGN_RSV = 2'b11
  } tcc_align_t;
  localparam logic [TCC_BYTE_W-1:0] TCC_MASK_4 = 12'h003;
  localparam logic [TCC_BYTE_W-1:0] TCC_MASK_16 = 12'h00f;
  localparam logic [TCC_BYTE_W-1:0] TCC_MASK_32 = 12'h01f;
  // ==========================================
  // Parser states
  typedef enum logic [1:0] {
    TCC_ST_CMD_A = 2'b00,
    TCC_ST_CMD_B = 2'b01,
    TCC_ST_DATA = 2'b10
  } tcc_state_t;
endpackage

// File: core/tcc_checker.sv
// Transmit command word parser, length checker and data lane stripper
`timescale 1ns/1ns
module tcc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Words from the transmit data FIFO
  input wire logic word_valid,
  input wire logic [tcc_pkg::TCC_WORD_W-1:0] word_data,
  // Control
  input wire logic checksum_engine_enable,
  input wire logic error_clear,
  // Stripped data towards the transmitter
  output logic out_valid,
  output logic [tcc_pkg::TCC_WORD_W-1:0] out_data,
  output logic [tcc_pkg::TCC_LANES-1:0] out_be,
  output logic out_first_segment,
  output logic out_last_segment,
  // Packet controls
  output logic tx_checksum_request,
  output logic crc_append,
  output logic pad_enable,
  output logic [tcc_pkg::TCC_SIZE_W-1:0] packet_length,
  // Status and flags
  output logic status_valid,
  output logic [tcc_pkg::TCC_TAG_W-1:0] status_tag,
  output logic buffer_loaded_flag,
  output logic transmit_error_flag
);
  import tcc_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic [TCC_WIDX_W-1:0] buf_words(input logic [TCC_OFF_W-1:0] off,
      input logic [TCC_SIZE_W-1:0] size, input logic [1:0] align);
    logic [TCC_BYTE_W-1:0] bytes;
    logic [TCC_BYTE_W-1:0] mask;
    logic [TCC_BYTE_W-1:0] rounded;
    bytes = TCC_BYTE_W'(off) + TCC_BYTE_W'(size);
    case (align)
      TCC_ALIGN_16: mask = TCC_MASK_16;
      TCC_ALIGN_32: mask = TCC_MASK_32;
      default: mask = TCC_MASK_4;
    endcase
    rounded = (bytes + mask) & ~mask;
    buf_words = rounded[TCC_BYTE_W-1:2];
  endfunction

  function automatic logic [TCC_LANES-1:0] lane_en(input logic [TCC_WIDX_W-1:0] widx,
      input logic [TCC_OFF_W-1:0] off, input logic [TCC_SIZE_W-1:0] size);
    logic [TCC_BYTE_W-1:0] b;
    logic [TCC_BYTE_W-1:0] lo;
    logic [TCC_BYTE_W-1:0] hi;
    lo = TCC_BYTE_W'(off);
    hi = TCC_BYTE_W'(off) + TCC_BYTE_W'(size);
    for (int i = 0; i < TCC_LANES; i++) begin
      b = {widx, 2'(i)};
      lane_en[i] = (b >= lo) && (b < hi);
    end
  endfunction

  function automatic logic [2:0] pop4(input logic [TCC_LANES-1:0] v);
    pop4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction

  // ==========================================
  // State
  tcc_state_t state_r;
  logic [TCC_WORD_W-1:0] cmd_a_r;
  logic [TCC_WORD_W-1:0] pkt_cmd_b_r;
  logic [TCC_WIDX_W-1:0] widx_r;
  logic [TCC_WIDX_W-1:0] words_r;
  logic [TCC_SUM_W-1:0] size_sum_r;
  logic [TCC_SUM_W-1:0] deliv_sum_r;
  logic eval_r;
  logic out_valid_r;
  logic [TCC_WORD_W-1:0] out_data_r;
  logic [TCC_LANES-1:0] out_be_r;
  logic out_fs_r;
  logic out_ls_r;
  logic chk_req_r;
  logic crc_append_r;
  logic pad_enable_r;
  logic status_valid_r;
  logic loaded_r;
  logic err_r;

  logic [TCC_OFF_W-1:0] a_off;
  logic [TCC_SIZE_W-1:0] a_size;
  logic [1:0] a_align;
  logic a_fs;
  logic a_ls;
  logic a_ioc;
  logic [TCC_LANES-1:0] cur_be;
  logic [TCC_WIDX_W-1:0] new_words;
  logic take_b;
  logic take_data;
  logic buf_done;
  logic b_mismatch;
  logic len_mismatch;
  logic err_set;

  assign a_off = cmd_a_r[TCC_A_OFF_LSB +: TCC_OFF_W];
  assign a_size = cmd_a_r[TCC_SIZE_W-1:0];
  assign a_align = cmd_a_r[TCC_A_ALIGN_LSB +: 2];
  assign a_fs = cmd_a_r[TCC_A_FS_BIT];
  assign a_ls = cmd_a_r[TCC_A_LS_BIT];
  assign a_ioc = cmd_a_r[TCC_A_IOC_BIT];
  assign new_words = buf_words(a_off, a_size, a_align);
  assign cur_be = lane_en(widx_r, a_off, a_size);
  assign take_b = (state_r == TCC_ST_CMD_B) && word_valid;
  assign take_data = (state_r == TCC_ST_DATA) && word_valid;
  assign buf_done = (take_data && (widx_r == words_r - 10'h001)) ||
                    (take_b && (new_words == 10'h000));
  assign b_mismatch = take_b && !a_fs && (word_data != pkt_cmd_b_r);
  assign len_mismatch = (size_sum_r != TCC_SUM_W'(pkt_cmd_b_r[TCC_SIZE_W-1:0])) ||
                        (deliv_sum_r != TCC_SUM_W'(pkt_cmd_b_r[TCC_SIZE_W-1:0]));
  assign err_set = (eval_r && len_mismatch) || b_mismatch;

  // ==========================================
  // Parser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= TCC_ST_CMD_A;
      cmd_a_r <= TCC_CMD_RST;
      widx_r <= 10'h000;
      words_r <= 10'h000;
    end else begin
      case (state_r)
        TCC_ST_CMD_A: begin
          if (word_valid) begin
            cmd_a_r <= word_data;
            state_r <= TCC_ST_CMD_B;
          end
        end
        TCC_ST_CMD_B: begin
          if (word_valid) begin
            widx_r <= 10'h000;
            words_r <= new_words;
            state_r <= (new_words == 10'h000) ? TCC_ST_CMD_A : TCC_ST_DATA;
          end
        end
        TCC_ST_DATA: begin
          if (word_valid) begin
            widx_r <= widx_r + 10'h001;
            if (buf_done) begin
              state_r <= TCC_ST_CMD_A;
            end
          end
        end
        default: state_r <= TCC_ST_CMD_A;
      endcase
    end
  end

  // ==========================================
  // Packet controls, latched from the first segment only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_cmd_b_r <= TCC_CMD_RST;
      chk_req_r <= 1'b0;
      crc_append_r <= 1'b1;
      pad_enable_r <= 1'b1;
    end else if (take_b && a_fs) begin
      pkt_cmd_b_r <= word_data;
      chk_req_r <= word_data[TCC_B_CK_BIT] && checksum_engine_enable;
      // CRC suppress, overridden by pad disable
      crc_append_r <= !word_data[TCC_B_NOCRC_BIT] || word_data[TCC_B_NOPAD_BIT];
      pad_enable_r <= !word_data[TCC_B_NOPAD_BIT];
    end
  end

  // ==========================================
  // Running totals
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      size_sum_r <= TCC_SUM_RST;
      deliv_sum_r <= TCC_SUM_RST;
    end else if (take_b) begin
      size_sum_r <= (a_fs ? TCC_SUM_RST : size_sum_r) + TCC_SUM_W'(a_size);
      if (a_fs) begin
        deliv_sum_r <= TCC_SUM_RST;
      end
    end else if (take_data) begin
      deliv_sum_r <= deliv_sum_r + TCC_SUM_W'(pop4(cur_be));
    end
  end

  // Compare one cycle after the final word so both totals have settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eval_r <= 1'b0;
      status_valid_r <= 1'b0;
    end else begin
      eval_r <= buf_done && a_ls;
      status_valid_r <= eval_r;
    end
  end

  // ==========================================
  // Stripped data path; whole offset and padding DWORDs vanish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r <= TCC_CMD_RST;
      out_be_r <= 4'h0;
      out_fs_r <= 1'b0;
      out_ls_r <= 1'b0;
    end else begin
      // drop words with no valid lane
      out_valid_r <= take_data && (cur_be != 4'h0);
      if (take_data) begin
        out_data_r <= word_data;
        out_be_r <= cur_be;
        out_fs_r <= a_fs;
        out_ls_r <= a_ls;
      end
    end
  end

  // ==========================================
  // Flags; a set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      loaded_r <= buf_done && a_ioc;
      err_r <= err_set || (err_r && !error_clear);
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_data_r;
  assign out_be = out_be_r;
  assign out_first_segment = out_fs_r;
  assign out_last_segment = out_ls_r;
  assign tx_checksum_request = chk_req_r;
  assign crc_append = crc_append_r;
  assign pad_enable = pad_enable_r;
  assign packet_length = pkt_cmd_b_r[TCC_SIZE_W-1:0];
  assign status_valid = status_valid_r;
  assign status_tag = pkt_cmd_b_r[TCC_B_TAG_LSB +: TCC_TAG_W];
  assign buffer_loaded_flag = loaded_r;
  assign transmit_error_flag = err_r;

  // ==========================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_first_b;
    take_b && a_fs;
  endsequence
  sequence s_final_word;
    buf_done && a_ls;
  endsequence

  a_err_on_len: assert property (s_final_word ##1 len_mismatch |=> err_r)
    else $error("length mismatch did not raise error");
  a_err_on_deliv: assert property (eval_r && deliv_sum_r != TCC_SUM_W'(packet_length)
      |=> err_r)
    else $error("delivered count mismatch missed");
  a_err_sticky: assert property (err_r && !error_clear |=> err_r)
    else $error("error flag dropped without clear");
  a_cmdb_differs: assert property (b_mismatch |=> err_r)
    else $error("word B mismatch not flagged");
  a_tag_status: assert property (s_final_word |-> ##2 status_valid &&
      status_tag == $past(pkt_cmd_b_r[31:16], 2))
    else $error("status tag not the packet tag");
  a_cksum_req: assert property (s_first_b |=> tx_checksum_request ==
      ($past(word_data[14]) && $past(checksum_engine_enable)))
    else $error("checksum request wrong");
  a_crc_pad: assert property (s_first_b |=> (crc_append == (!$past(word_data[13]) ||
      $past(word_data[12]))) && (pad_enable == !$past(word_data[12])))
    else $error("CRC or pad control wrong");
  a_loaded_pulse: assert property (buf_done && a_ioc |=> buffer_loaded_flag
      ##1 !buffer_loaded_flag || $past(buf_done))
    else $error("loaded flag not pulsed");
  a_pad_dropped: assert property (take_data && cur_be == 4'h0 |=> !out_valid)
    else $error("padding word passed on");
  a_first_lane: assert property (take_data && widx_r == 10'(a_off[4:2]) && a_size != 0
      |=> out_valid && out_be[$past(a_off[1:0])])
    else $error("first data lane wrong");
  a_sum_restart: assert property (s_first_b |=> size_sum_r ==
      TCC_SUM_W'($past(a_size)))
    else $error("running total not restarted");
endmodule // tcc_checker

// File: verification/tcc_host_model.sv
// Host model writing command words and padded buffers into the checker
`timescale 1ns/1ns
module tcc_host_model (
  // Clock
  input wire logic clk,
  // Words towards the checker
  output logic word_valid,
  output logic [31:0] word_data
);
  import tcc_pkg::*;
  initial begin
    word_valid = 1'b0;
    word_data = 32'h0000_0000;
  end
  // ==========================================
  // Buffer writer, called just after a rising edge
  task automatic send(input logic [4:0] off, input logic [1:0] al, input logic [2:0] fli,
      input logic [10:0] size, input logic [31:0] b);
    int m;
    int n;
    // pad the buffer up to the chosen end alignment
    m = (al == 2'b01) ? 16 : (al == 2'b10) ? 32 : 4;
    n = (int'(off) + int'(size) + m - 1) / m * m / 4;
    // reserved bits zero, size excludes offset and pad
    word_valid <= 1'b1;
    word_data <= {fli[0], 5'h00, al, 3'h0, off, 2'h0, fli[2:1], 1'b0, size};
    @(posedge clk);
    word_data <= b;
    @(posedge clk);
    for (int k = 0; k < n; k++) begin
      word_data <= {8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1), 8'(4 * k)};
      @(posedge clk);
    end
  endtask
  // Idle bus shows no stale word
  task automatic idle();
    word_valid <= 1'b0;
    word_data <= ~word_data;
  endtask
endmodule // tcc_host_model

// File: verification/test_tcc_checker.sv
// Self-checking bench for the transmit command word checker
`timescale 1ns/1ns
module test_tcc_checker;
  import tcc_pkg::*;
  logic clk, rst_n, word_valid, checksum_engine_enable, error_clear;
  logic [31:0] word_data, out_data;
  logic [3:0] out_be;
  logic out_valid, out_first_segment, out_last_segment, tx_checksum_request;
  logic crc_append, pad_enable, status_valid, buffer_loaded_flag, transmit_error_flag;
  logic [10:0] packet_length;
  logic [15:0] status_tag;
  logic [3:0] beq[$];
  int mismatches, checked, nbytes, nstat, nload;
  tcc_checker i_tcc_checker (.clk(clk), .rst_n(rst_n), .word_valid(word_valid),
    .word_data(word_data), .checksum_engine_enable(checksum_engine_enable),
    .error_clear(error_clear), .out_valid(out_valid), .out_data(out_data), .out_be(out_be),
    .out_first_segment(out_first_segment), .out_last_segment(out_last_segment),
    .tx_checksum_request(tx_checksum_request), .crc_append(crc_append),
    .pad_enable(pad_enable), .packet_length(packet_length), .status_valid(status_valid),
    .status_tag(status_tag), .buffer_loaded_flag(buffer_loaded_flag),
    .transmit_error_flag(transmit_error_flag));
  tcc_host_model i_tcc_host_model (.clk(clk), .word_valid(word_valid), .word_data(word_data));
  // ==========================================
  // Clock and output monitor
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      nbytes += $countones(out_be);
      beq.push_back(out_be);
    end
    if (status_valid === 1'b1) nstat++;
    if (buffer_loaded_flag === 1'b1) nload++;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic clr();
    @(posedge clk);
    nbytes = 0;
    nstat = 0;
    nload = 0;
    beq.delete();
  endtask
  // Bounded wait for the packet status pulse
  task automatic done();
    i_tcc_host_model.idle();
    for (int i = 0; i < 40 && nstat < 1; i++) begin
      @(posedge clk);
      #1;
    end
    if (nstat < 1) begin
      mismatches++;
      results();
    end
    @(posedge clk);
    #1;
  endtask
  task automatic clrerr();
    @(posedge clk);
    error_clear <= 1'b1;
    @(posedge clk);
    error_clear <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // Test sequence
  initial begin
    rst_n = 1'b0;
    checksum_engine_enable = 1'b0;
    error_clear = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    clr();
    checksum_engine_enable <= 1'b1;
    i_tcc_host_model.send(5'h00, 2'b00, 3'b111, 11'h005, 32'h1234_4005);
    done();
    chk(nbytes, 5);
    chk(nload, 1);
    chk(status_tag, 16'h1234);
    chk(packet_length, 11'h005);
    chk(tx_checksum_request, 1'b1);
    chk({crc_append, pad_enable, transmit_error_flag}, 3'h6);
    chk({beq[0], beq[1]}, 8'hf1);
    chk(out_data, 32'h0706_0504);
    chk({out_first_segment, out_last_segment}, 2'h3);
    $display("single buffer test done");
    clr();
    i_tcc_host_model.send(5'h06, 2'b01, 3'b110, 11'h003, 32'h00aa_0003);
    done();
    chk(beq.size(), 2);
    chk({beq[0], beq[1]}, 8'hc1);
    chk({nload, tx_checksum_request}, 2'h0);
    $display("offset test done");
    for (int a = 0; a < 4; a++) begin
      clr();
      i_tcc_host_model.send(5'h03, 2'(a), 3'b111, 11'h006, 32'h0007_0006);
      done();
      chk(nbytes, 6);
      chk({nload[0], transmit_error_flag}, 2'h2);
    end
    $display("alignment test done");
    clr();
    checksum_engine_enable <= 1'b0;
    i_tcc_host_model.send(5'h01, 2'b10, 3'b100, 11'h004, 32'h0042_600b);
    i_tcc_host_model.send(5'h00, 2'b00, 3'b011, 11'h007, 32'h0042_600b);
    done();
    chk(nbytes, 11);
    chk({crc_append, pad_enable, tx_checksum_request}, 3'h2);
    chk({packet_length, transmit_error_flag}, {11'h00b, 1'b0});
    chk({out_first_segment, out_last_segment}, 2'h1);
    $display("two buffer test done");
    clr();
    i_tcc_host_model.send(5'h00, 2'b00, 3'b110, 11'h004, 32'h0043_3004);
    done();
    chk({crc_append, pad_enable}, 2'h2);
    $display("pad suppress test done");
    clr();
    i_tcc_host_model.send(5'h00, 2'b00, 3'b110, 11'h005, 32'h0044_0006);
    done();
    chk(transmit_error_flag, 1'b1);
    clrerr();
    chk(transmit_error_flag, 1'b0);
    $display("length mismatch test done");
    clr();
    i_tcc_host_model.send(5'h00, 2'b00, 3'b100, 11'h004, 32'h0045_0008);
    i_tcc_host_model.send(5'h00, 2'b00, 3'b010, 11'h004, 32'h0046_0008);
    done();
    chk({nbytes, transmit_error_flag}, {32'h8, 1'b1});
    clrerr();
    chk(transmit_error_flag, 1'b0);
    $display("command mismatch test done");
    results();
  end
endmodule // test_tcc_checker
